// ===== logic/srw_pkg.sv
// package: constants and carrier types for the supervisor reset/watchdog block
package srw_pkg;

  // =========================================================
  // timebase
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS = 100;

  // =========================================================
  // timing figures in their own units
  localparam int unsigned HOLD_SHORT_MS = 10;
  localparam int unsigned HOLD_LONG_MS = 150;
  localparam int unsigned WDOG_WINDOW_MS = 1500;
  localparam int unsigned STROBE_MIN_NS = 150;

  // least times round up to whole cycles
  localparam int unsigned HOLD_SHORT_CYC = HOLD_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned HOLD_LONG_CYC = HOLD_LONG_MS * (CLK_HZ / 1000);
  localparam int unsigned WDOG_WINDOW_CYC = WDOG_WINDOW_MS * (CLK_HZ / 1000);
  localparam int unsigned STROBE_MIN_CYC =
    (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 32;

  // =========================================================
  // reset values
  localparam logic RST_ASSERTED = 1'b1;

  typedef enum logic [1:0] {
    SRW_RUN = 2'b00,
    SRW_HOLD_IN = 2'b01,
    SRW_STRETCH = 2'b10
  } srw_state_t;

  // synchronised pin inputs
  typedef struct packed {
    logic manualResetN;
    logic strobe;
  } srw_pins_t;

  // reason for the last reset, exported as status
  typedef struct packed {
    logic supply;
    logic manual;
    logic watchdog;
  } srw_cause_t;

endpackage

// ===== logic/srw_supervisor.sv
// supervisor: reset stretcher with manual reset, supply monitor and watchdog
// =========================================================
module srw_supervisor
  import srw_pkg::*;
#(
  parameter int unsigned HOLD_SHORT = srw_pkg::HOLD_SHORT_CYC, // short hold, cycles
  parameter int unsigned HOLD_LONG = srw_pkg::HOLD_LONG_CYC, // long hold, cycles
  parameter int unsigned WDOG_WINDOW = srw_pkg::WDOG_WINDOW_CYC, // watchdog window, cycles
  parameter bit ACTIVE_HIGH = 1'b0, // output polarity
  parameter bit HAS_SELECT = 1'b1, // timeout select present
  parameter bit HAS_WATCHDOG = 1'b1 // watchdog present
) (
  input wire logic clk, // 10 MHz timebase
  input wire logic sys_rst, // synchronous reset, active high
  input wire logic supplyLow, // supply below threshold indication
  input wire logic manual_reset_n, // manual reset pin, active low
  input wire logic watchdog_strobe_in, // watchdog toggle pin
  input wire logic timeout_select, // hold period select pin
  output logic resetOut, // reset to processor, polarity per ACTIVE_HIGH
  output logic resetActive, // reset asserted, active high
  output srw_pkg::srw_cause_t resetCause // sources of the last reset
);
  import srw_pkg::*;

  // =========================================================
  // state
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] selSync;
    logic strobePrev;
    logic supplyQ;
    srw_state_t state;
    logic [CNT_W-1:0] holdCnt;
    logic [CNT_W-1:0] holdLen;
    logic [CNT_W-1:0] wdogCnt;
    logic [CNT_W-1:0] quietCnt;
    logic asserted;
    srw_cause_t cause;
  } srw_regs_t;

  srw_regs_t st_r, st_nxt;
  srw_pins_t pins;
  logic strobeEdge;
  logic wdogExpire;
  logic holdSource;
  logic [CNT_W-1:0] selLen;

  // first stage feeds only the second stage
  assign pins = srw_pins_t'(st_r.sync2);
  assign strobeEdge = HAS_WATCHDOG && (pins.strobe != st_r.strobePrev);
  assign wdogExpire = HAS_WATCHDOG && (st_r.wdogCnt >= CNT_W'(WDOG_WINDOW - 1));
  assign holdSource = st_r.supplyQ || !pins.manualResetN;
  // select sampled only when a period starts, so a mid-period change waits
  assign selLen = (HAS_SELECT && st_r.selSync[1]) ?
    CNT_W'(HOLD_LONG) : CNT_W'(HOLD_SHORT);

  // =========================================================
  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {manual_reset_n, watchdog_strobe_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.strobePrev = pins.strobe;
    st_nxt.selSync = {st_r.selSync[0], timeout_select};
    // checker aid: cycles held with no source active
    st_nxt.quietCnt = (st_r.asserted && !holdSource) ? st_r.quietCnt + CNT_W'(1) : '0;
    // supply indication comes from on-chip analogue logic, same domain
    st_nxt.supplyQ = supplyLow;
    unique case (st_r.state)
      SRW_RUN: begin
        if (holdSource) begin
          st_nxt.state = SRW_HOLD_IN;
          st_nxt.asserted = 1'b1;
          st_nxt.cause = '{supply: st_r.supplyQ, manual: !pins.manualResetN, watchdog: 1'b0};
          st_nxt.wdogCnt = '0;
        end else if (wdogExpire) begin
          st_nxt.state = SRW_STRETCH;
          st_nxt.asserted = 1'b1;
          st_nxt.holdLen = selLen;
          st_nxt.holdCnt = '0;
          st_nxt.cause = '{supply: 1'b0, manual: 1'b0, watchdog: 1'b1};
          st_nxt.wdogCnt = '0;
        end else if (strobeEdge) begin
          st_nxt.wdogCnt = '0;
        end else if (HAS_WATCHDOG) begin
          st_nxt.wdogCnt = st_r.wdogCnt + CNT_W'(1);
        end
      end
      SRW_HOLD_IN: begin
        // held as long as a source is active
        st_nxt.wdogCnt = '0;
        if (!holdSource) begin
          st_nxt.state = SRW_STRETCH;
          st_nxt.holdLen = selLen;
          st_nxt.holdCnt = '0;
        end
      end
      SRW_STRETCH: begin
        if (holdSource) begin
          st_nxt.state = SRW_HOLD_IN;
          st_nxt.cause.supply = st_r.cause.supply | st_r.supplyQ;
          st_nxt.cause.manual = st_r.cause.manual | !pins.manualResetN;
        end else if (st_r.holdCnt >= st_r.holdLen - CNT_W'(1)) begin
          st_nxt.state = SRW_RUN;
          st_nxt.asserted = 1'b0;
          st_nxt.wdogCnt = '0;
        end else begin
          st_nxt.holdCnt = st_r.holdCnt + CNT_W'(1);
        end
      end
      default: begin
        st_nxt.state = SRW_HOLD_IN;
        st_nxt.asserted = 1'b1;
      end
    endcase
    if (sys_rst) begin
      st_nxt = '0;
      st_nxt.sync1 = 2'h3;
      st_nxt.sync2 = 2'h3;
      // strobe history matches the synchroniser, so reset leaves no false edge
      st_nxt.strobePrev = 1'b1;
      st_nxt.state = SRW_HOLD_IN;
      st_nxt.asserted = RST_ASSERTED;
      st_nxt.holdLen = CNT_W'(HOLD_SHORT);
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // =========================================================
  // outputs
  assign resetActive = st_r.asserted;
  assign resetOut = ACTIVE_HIGH ? st_r.asserted : !st_r.asserted;
  assign resetCause = st_r.cause;

  // =========================================================
  // checks
  supply_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
    st_r.supplyQ |=> st_r.asserted)
    else $error("reset not asserted while supply low");

  manual_holds_a: assert property (@(posedge clk) disable iff (sys_rst)
    !pins.manualResetN |=> st_r.asserted)
    else $error("reset not asserted while manual reset low");

  stretch_min_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SRW_STRETCH && st_r.holdCnt == '0 && !holdSource)
      |-> st_r.asserted [*8])
    else $error("hold period ended too soon");

  wdog_frozen_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.asserted && $past(st_r.asserted)) |-> st_r.wdogCnt == '0)
    else $error("watchdog counted during reset");

  wdog_restart_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(st_r.asserted) |-> st_r.wdogCnt == '0 ##1 st_r.wdogCnt <= CNT_W'(1))
    else $error("watchdog not restarted on release");

  edge_clears_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SRW_RUN && strobeEdge && !holdSource && !wdogExpire)
      |=> st_r.wdogCnt == '0)
    else $error("strobe edge did not clear watchdog");

  wdog_fires_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SRW_RUN && wdogExpire && !holdSource)
      |=> st_r.asserted && st_r.cause.watchdog)
    else $error("watchdog expiry missed");

  select_latched_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SRW_STRETCH && $past(st_r.state) == SRW_STRETCH)
      |-> $stable(st_r.holdLen))
    else $error("hold length changed mid period");

  select_length_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SRW_HOLD_IN && !holdSource)
      |=> st_r.holdLen == $past(selLen))
    else $error("wrong hold length chosen");

  stroke_short_a: assert property (@(posedge clk) disable iff (sys_rst)
    (pins.strobe != st_r.strobePrev) |-> (strobeEdge || !HAS_WATCHDOG))
    else $error("short strobe pulse missed");

  // long holds are measured by a counter, not by unrolled repetition
  release_quiet_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(st_r.asserted) |-> st_r.quietCnt >= CNT_W'(HOLD_SHORT))
    else $error("reset released before a full hold period");

  select_encode_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SRW_STRETCH && $past(st_r.state) != SRW_STRETCH)
      |-> st_r.holdLen == (($past(st_r.selSync[1]) && HAS_SELECT) ? CNT_W'(HOLD_LONG)
        : CNT_W'(HOLD_SHORT)))
    else $error("hold length does not match select");

  wdog_count_a: assert property (@(posedge clk) disable iff (sys_rst)
    (HAS_WATCHDOG && st_r.state == SRW_RUN && !holdSource && !wdogExpire && !strobeEdge)
      |=> st_r.wdogCnt == $past(st_r.wdogCnt) + CNT_W'(1))
    else $error("watchdog did not advance");

  wdog_window_a: assert property (@(posedge clk) disable iff (sys_rst)
    (st_r.state == SRW_RUN) |-> st_r.wdogCnt < CNT_W'(WDOG_WINDOW))
    else $error("watchdog ran past its window");

  manual_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!manual_reset_n [*3]) |=> st_r.asserted)
    else $error("manual reset slow through synchroniser");

endmodule

// ===== dv/srw_cpu_model.sv
// partner model: processor software servicing the watchdog strobe
module srw_cpu_model (
  input wire logic clk, // timebase
  input wire logic resetOut, // supervisor reset, active low
  input wire logic run, // software alive
  input wire logic pulse, // emit short complete pulses
  input wire logic [7:0] gap, // cycles between strobe actions
  output logic strobe // watchdog strobe pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  initial begin
    strobe = 1'b0;
    cnt = 8'h00;
  end
  // =======================================
  // software loop
  always @(posedge clk) begin
    if (!resetOut || !run) begin
      cnt <= 8'h00; // a processor held in reset runs no code
    end else if (cnt >= gap) begin
      cnt <= 8'h00;
      strobe <= pulse ? 1'b1 : !strobe;
    end else begin
      cnt <= cnt + 8'h01;
      if (pulse && cnt == 8'h01) strobe <= 1'b0;
    end
  end
endmodule

// ===== dv/tb.sv
// testbench: random and corner-case checks of the supervisor
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin nMismatch++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import srw_pkg::*;
  localparam int HS = 20;
  localparam int HL = 40;
  localparam int WD = 60;
  logic clk, sysRst, supplyLow, manualN, sel, run, pulse, strobe, resetOut, resetActive;
  logic [7:0] gap;
  srw_cause_t cause;
  int nMismatch, testsRun;
  srw_supervisor #(.HOLD_SHORT(HS), .HOLD_LONG(HL), .WDOG_WINDOW(WD)) dut (.clk(clk),
    .sys_rst(sysRst), .supplyLow(supplyLow), .manual_reset_n(manualN),
    .watchdog_strobe_in(strobe), .timeout_select(sel), .resetOut(resetOut),
    .resetActive(resetActive), .resetCause(cause));
  srw_cpu_model cpu (.clk(clk), .resetOut(resetOut), .run(run), .pulse(pulse), .gap(gap),
    .strobe(strobe));
  task automatic closeOut();
    if (nMismatch == 0 && testsRun > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // bounded, so a stuck reset output ends the run
  task automatic waitAct(input logic lvl, input int lim, output int n);
    n = 0;
    while (resetActive !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        nMismatch++;
        $display("[ERR] %0t reset output stuck", $time);
        closeOut();
      end
    end
  endtask
  // one source for len cycles; select flips once the stretch is under way
  task automatic srcPulse(input int w, input int len, input logic s0, input logic s1);
    int n;
    int h;
    h = s0 ? HL : HS;
    @(posedge clk);
    sel <= s0;
    if (w) manualN <= 1'b0;
    else supplyLow <= 1'b1;
    waitAct(1'b1, 5, n);
    `CHK(n, w ? 3 : 2)
    `CHK(resetOut, 1'b0)
    `CHK(w ? cause.manual : cause.supply, 1'b1)
    repeat (len) @(posedge clk);
    `CHK(resetActive, 1'b1)
    supplyLow <= 1'b0;
    manualN <= 1'b1;
    repeat (8) @(posedge clk);
    sel <= s1;
    waitAct(1'b0, h + 8, n);
    `CHK((n + 8) inside {[h + 1:h + 8]}, 1'b1)
  endtask
  // =======================================
  // stimulus
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    nMismatch++;
    $display("[ERR] %0t run timed out", $time);
    closeOut();
  end
  initial begin
    int n;
    {sysRst, supplyLow, manualN, sel, run, pulse} = 6'b101010;
    gap = 8'h0A;
    nMismatch = 0;
    testsRun = 0;
    void'($urandom(44185));
    repeat (20) @(posedge clk);
    sysRst <= 1'b0;
    waitAct(1'b0, HS + 10, n);
    `CHK(resetOut, 1'b1)
    srcPulse(0, 1, 1'b0, 1'b1);
    srcPulse(1, 3, 1'b1, 1'b0);
    repeat (6) srcPulse($urandom_range(1), $urandom_range(40, 1), $urandom_range(1), 1'b0);
    gap <= 8'($urandom_range(WD - 10, 3));
    repeat (400) @(posedge clk);
    `CHK(resetActive, 1'b0)
    pulse <= 1'b1;
    repeat (400) @(posedge clk);
    `CHK(resetActive, 1'b0)
    run <= 1'b0;
    waitAct(1'b1, WD + 8, n);
    `CHK(cause.watchdog, 1'b1)
    waitAct(1'b0, HL + 8, n);
    `CHK(n inside {[HS - 1:HS + 6]}, 1'b1)
    waitAct(1'b1, WD + 10, n);
    `CHK(n inside {[WD - 1:WD + 6]}, 1'b1)
    closeOut();
  end
endmodule
